// ===== core/caa_alarm_aggregator.sv
// Operation
// - the summary bit reads 1 while any flag is set with its mask bit clear.
// - the lane FIFO fault flag (bit 5) sets when any active lane FIFO overflows or underflows.
// - writing 1 to a flag bit clears it and writing 0 leaves it alone.
// - the PLL unlock flag (bit 4) sets whenever the PLL is not locked.
// - in 8b/10b modes the link flag (bit 3) sets while the link is enabled but not in data state.
// - the clock realign flag (bit 2) sets whenever a SYSREF realigns internal clocks.
// - the phase upset flag (bit 1) sets on link disable, oscillator sync or A/B phase mismatch.
// - the divider mismatch flag (bit 0) sets while the A and B dividers disagree.
// - power-on or soft reset sets all six flags and all six mask bits to 1.
// - with the link disabled all flags but divider mismatch are undefined; software clears after.
// - a set mask bit keeps the flag at the same position out of the summary bit.
// - writing 1 to the lane FIFO fault flag also clears all sixteen per-lane fault bits.
`timescale 1ns/10ps
module caa_alarm_aggregator
  import caa_pkg::*;
#(
  parameter int LANES = 16
)
(
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       rstn,
  input  wire logic                       soft_reset,
  // register port
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  input  wire logic [caa_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [caa_pkg::DATA_W-1:0] reg_wdata,
  output logic      [caa_pkg::DATA_W-1:0] reg_rdata,
  // lane fifo events
  input  wire logic [LANES-1:0]           lane_fifo_fault,
  input  wire logic [LANES-1:0]           lane_active,
  // pll and link
  input  wire logic                       pll_locked,
  input  wire logic                       serial_link_enable,
  input  wire logic                       link_in_data_state,
  input  wire logic                       encoding_64b66b,
  input  wire logic                       link_start,
  input  wire logic                       link_realign,
  // clocking events
  input  wire logic                       sysref_realign,
  input  wire logic                       nco_sync,
  input  wire logic                       nco_phase_mismatch,
  input  wire logic                       divider_mismatch,
  // calibration status pin
  input  wire logic                       cal_status_sel,
  input  wire logic                       cal_status_other,
  output logic                            cal_status_pin
);

  import caa_pkg::*;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] t);
    addr_hit = (a == t);
  endfunction : addr_hit

  logic             rst_n_sync;
  caa_state_s       st;
  caa_state_s       next_st;
  logic [5:0]       set_v;
  logic [5:0]       clr_v;
  logic             pending;
  logic             wr_flags;
  logic             wr_mask;
  logic [LANES-1:0] lane_clr;
  logic [LANES-1:0] lane_bits;
  logic [15:0]      lane_word;
  logic             lane_fault_any;

  caa_reset_sync u_rsync (
    .clock      (clock),
    .rstn       (rstn),
    .rst_n_sync (rst_n_sync)
  );

  // write decode
  assign wr_flags = reg_wr && addr_hit(reg_addr, ADDR_ALARM_FLAGS);
  assign wr_mask  = reg_wr && addr_hit(reg_addr, ADDR_ALARM_MASK);

  // per-lane clear by write 1 to either byte
  always_comb begin
    lane_clr = '0;
    for (int i = 0; i < LANES; i++) begin
      if (i < 8) begin
        lane_clr[i] = reg_wr && addr_hit(reg_addr, ADDR_LANE_FAULT_LO) && reg_wdata[i % 8];
      end else begin
        lane_clr[i] = reg_wr && addr_hit(reg_addr, ADDR_LANE_FAULT_HI) && reg_wdata[i % 8];
      end
    end
  end

  caa_lane_faults #(
    .LANES (LANES)
  ) u_lanes (
    .clock      (clock),
    .rst_n      (rst_n_sync),
    .fault      (lane_fifo_fault),
    .active     (lane_active),
    .preset     (soft_reset),
    .clear_all  (wr_flags && reg_wdata[BIT_LANE_FIFO_FAULT]),
    .clear_bits (lane_clr),
    .lanes      (lane_bits)
  );

  always_comb begin
    lane_word            = '0;
    lane_word[LANES-1:0] = lane_bits;
  end

  // event sources
  assign lane_fault_any = |(lane_fifo_fault & lane_active);
  always_comb begin
    set_v                       = '0;
    set_v[BIT_LANE_FIFO_FAULT]  = lane_fault_any;
    set_v[BIT_PLL_UNLOCK]       = !pll_locked;
    if (encoding_64b66b) begin
      set_v[BIT_LINK_STATE] = link_start || link_realign;
    end else begin
      set_v[BIT_LINK_STATE] = serial_link_enable && !link_in_data_state;
    end
    set_v[BIT_CLOCK_REALIGN]    = sysref_realign;
    set_v[BIT_OSC_PHASE_UPSET]  = !serial_link_enable || nco_sync || nco_phase_mismatch;
    set_v[BIT_DIVIDER_MISMATCH] = divider_mismatch;
  end

  assign clr_v   = wr_flags ? reg_wdata[FLAG_W-1:0] : 6'h00;
  assign pending = |(st.flags & ~st.mask);

  // next state
  always_comb begin
    next_st = st;
    if (soft_reset) begin
      next_st.flags = RST_ALARM_FLAGS;
      next_st.mask  = RST_ALARM_MASK;
    end else begin
      next_st.flags = (st.flags & ~clr_v) | set_v;
      if (wr_mask) begin
        next_st.mask = reg_wdata[FLAG_W-1:0];
      end
    end
    next_st.pin = cal_status_sel ? pending : cal_status_other;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_ALARM_SUMMARY: next_st.rdata = {7'h00, pending};
        ADDR_ALARM_FLAGS:   next_st.rdata = {2'h0, st.flags};
        ADDR_ALARM_MASK:    next_st.rdata = {2'h0, st.mask};
        ADDR_LANE_FAULT_LO: next_st.rdata = lane_word[7:0];
        ADDR_LANE_FAULT_HI: next_st.rdata = lane_word[15:8];
        default:            next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      st <= '{flags: RST_ALARM_FLAGS, mask: RST_ALARM_MASK, rdata: RST_RDATA, pin: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata      = st.rdata;
  assign cal_status_pin = st.pin;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n_sync);

  logic [5:0] clr_only;
  logic [5:0] keep_v;
  logic       summary_ref;
  assign clr_only    = reg_wdata[5:0] & ~set_v;
  assign keep_v      = st.flags & ~reg_wdata[5:0];
  assign summary_ref = |(st.flags & ~st.mask);

  sequence s_read_summary;
    reg_rd && (reg_addr == ADDR_ALARM_SUMMARY);
  endsequence

  sequence s_read_flags;
    reg_rd && (reg_addr == ADDR_ALARM_FLAGS);
  endsequence

  sequence s_read_mask;
    reg_rd && (reg_addr == ADDR_ALARM_MASK);
  endsequence

  sequence s_flag_write;
    wr_flags && !soft_reset;
  endsequence

  property p_summary_read;
    s_read_summary |=> (reg_rdata == {7'h00, $past(summary_ref)});
  endproperty
  a_summary_read: assert property (p_summary_read) else $error("summary read wrong");

  property p_pin_route;
    cal_status_sel && (|(st.flags & ~st.mask)) |=> cal_status_pin;
  endproperty
  a_pin_route: assert property (p_pin_route) else $error("pin not driven by summary");

  property p_lane_fault;
    (|(lane_fifo_fault & lane_active)) |=> st.flags[BIT_LANE_FIFO_FAULT];
  endproperty
  a_lane_fault: assert property (p_lane_fault) else $error("lane fault flag not set");

  property p_w1c;
    s_flag_write |=> ((st.flags & $past(clr_only)) == 6'h00);
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");

  property p_w0_keep;
    s_flag_write |=> ((st.flags & $past(keep_v)) == $past(keep_v));
  endproperty
  a_w0_keep: assert property (p_w0_keep) else $error("write zero cleared a flag");

  property p_pll;
    !pll_locked |=> st.flags[BIT_PLL_UNLOCK];
  endproperty
  a_pll: assert property (p_pll) else $error("pll unlock flag not set");

  property p_link_8b;
    !encoding_64b66b && serial_link_enable && !link_in_data_state |=> st.flags[BIT_LINK_STATE];
  endproperty
  a_link_8b: assert property (p_link_8b) else $error("link flag not set");

  property p_link_64b;
    encoding_64b66b && (link_start || link_realign) |=> st.flags[BIT_LINK_STATE];
  endproperty
  a_link_64b: assert property (p_link_64b) else $error("link realign flag not set");

  property p_realign;
    sysref_realign |=> st.flags[BIT_CLOCK_REALIGN];
  endproperty
  a_realign: assert property (p_realign) else $error("realign flag not set");

  property p_nco;
    (!serial_link_enable || nco_sync || nco_phase_mismatch) |=> st.flags[BIT_OSC_PHASE_UPSET];
  endproperty
  a_nco: assert property (p_nco) else $error("phase upset flag not set");

  property p_div;
    divider_mismatch |=> st.flags[BIT_DIVIDER_MISMATCH];
  endproperty
  a_div: assert property (p_div) else $error("divider flag not set");

  property p_soft_reset;
    soft_reset |=> (st.flags == RST_ALARM_FLAGS) && (st.mask == RST_ALARM_MASK);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset preset wrong");

  property p_mask_all;
    (st.mask == 6'h3f) && !wr_mask ##0 s_read_summary |=> (reg_rdata == 8'h00);
  endproperty
  a_mask_all: assert property (p_mask_all) else $error("masked flag reached summary");

  property p_lane_clear;
    s_flag_write ##0 (reg_wdata[BIT_LANE_FIFO_FAULT] && !lane_fault_any) |=> (lane_bits == '0);
  endproperty
  a_lane_clear: assert property (p_lane_clear) else $error("lane faults not cleared");

  property p_set_wins;
    s_flag_write |=> ((st.flags & $past(set_v)) == $past(set_v));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a pending event");

  property p_reserved;
    s_read_flags |=> (reg_rdata[7:6] == 2'h0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

  property p_mask_rsvd;
    s_read_mask |=> (reg_rdata[7:6] == 2'h0);
  endproperty
  a_mask_rsvd: assert property (p_mask_rsvd) else $error("mask reserved bits nonzero");

  property p_pin_idle;
    cal_status_sel && !summary_ref |=> !cal_status_pin;
  endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("pin raised without alarm");

  property p_pin_other;
    !cal_status_sel |=> (cal_status_pin == $past(cal_status_other));
  endproperty
  a_pin_other: assert property (p_pin_other) else $error("pin not driven by other source");

  property p_summary_ro;
    reg_wr && (reg_addr == ADDR_ALARM_SUMMARY) && !soft_reset |=> $stable(st.mask);
  endproperty
  a_summary_ro: assert property (p_summary_ro) else $error("summary write changed mask");

  property p_flags_sticky;
    !wr_flags && !soft_reset |=> ((st.flags & $past(st.flags)) == $past(st.flags));
  endproperty
  a_flags_sticky: assert property (p_flags_sticky) else $error("flag lost without clear");

  property p_lane_sticky;
    !reg_wr && !soft_reset |=> ((lane_bits & $past(lane_bits)) == $past(lane_bits));
  endproperty
  a_lane_sticky: assert property (p_lane_sticky) else $error("lane bit lost");

endmodule : caa_alarm_aggregator

// ===== shared/caa_pkg.sv
package caa_pkg;

  // register map, byte addresses on the internal register port
  localparam logic [11:0] ADDR_ALARM_SUMMARY = 12'h2c0;
  localparam logic [11:0] ADDR_ALARM_FLAGS   = 12'h2c1;
  localparam logic [11:0] ADDR_ALARM_MASK    = 12'h2c2;
  localparam logic [11:0] ADDR_LANE_FAULT_LO = 12'h2c4;
  localparam logic [11:0] ADDR_LANE_FAULT_HI = 12'h2c5;

  // widths
  localparam int ADDR_W  = 12;
  localparam int DATA_W  = 8;
  localparam int FLAG_W  = 6;
  localparam int LANES_N = 16;

  // flag, mask and summary bit positions
  localparam int BIT_LANE_FIFO_FAULT  = 5;
  localparam int BIT_PLL_UNLOCK       = 4;
  localparam int BIT_LINK_STATE       = 3;
  localparam int BIT_CLOCK_REALIGN    = 2;
  localparam int BIT_OSC_PHASE_UPSET  = 1;
  localparam int BIT_DIVIDER_MISMATCH = 0;
  localparam int BIT_SUMMARY          = 0;

  // reset values
  localparam logic [5:0]  RST_ALARM_FLAGS = 6'h3f;
  localparam logic [5:0]  RST_ALARM_MASK  = 6'h3f;
  localparam logic [15:0] RST_LANE_FAULTS = 16'hffff;
  localparam logic [7:0]  RST_RDATA       = 8'h00;

  typedef struct packed {
    logic [5:0] flags;
    logic [5:0] mask;
    logic [7:0] rdata;
    logic       pin;
  } caa_state_s;

  typedef struct packed {
    logic [15:0] lanes;
  } caa_lane_s;

  typedef struct packed {
    logic [1:0] stages;
  } caa_rsync_s;

endpackage : caa_pkg

// ===== core/caa_reset_sync.sv
`timescale 1ns/10ps
module caa_reset_sync
  import caa_pkg::*;
(
  // clock and raw reset
  input  wire logic clock,
  input  wire logic rstn,
  // released reset
  output logic      rst_n_sync
);

  caa_rsync_s st;
  caa_rsync_s next_st;

  // shift ones in after release
  always_comb begin
    next_st        = st;
    next_st.stages = {st.stages[0], 1'b1};
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rst_n_sync = st.stages[1];

endmodule : caa_reset_sync

// ===== core/caa_lane_faults.sv
`timescale 1ns/10ps
module caa_lane_faults
  import caa_pkg::*;
#(
  parameter int LANES = 16
)
(
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // lane events
  input  wire logic [LANES-1:0] fault,
  input  wire logic [LANES-1:0] active,
  // software control
  input  wire logic             preset,
  input  wire logic             clear_all,
  input  wire logic [LANES-1:0] clear_bits,
  // lane state
  output logic      [LANES-1:0] lanes
);

  typedef struct packed {
    logic [LANES-1:0] lanes;
  } caa_lreg_s;

  caa_lreg_s st;
  caa_lreg_s next_st;

  // per-lane sticky faults, set beats clear
  always_comb begin
    next_st = st;
    if (preset) begin
      next_st.lanes = {LANES{1'b1}};
    end else begin
      next_st.lanes = st.lanes & ~(clear_bits | {LANES{clear_all}});
      next_st.lanes = next_st.lanes | (fault & active);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{lanes: {LANES{1'b1}}};
    end else begin
      st <= next_st;
    end
  end

  assign lanes = st.lanes;

endmodule : caa_lane_faults

// ===== verif/tb_converter_alarm_aggregator.sv
`timescale 1ns/10ps
module tb_converter_alarm_aggregator;
  import caa_pkg::*;

  localparam int EBIT [10] = '{0, 1, 2, 3, 4, 5, 1, 1, 3, 3};

  logic        clock      = 1'b0;
  logic        rstn       = 1'b0;
  logic        soft_reset = 1'b0;
  logic        reg_wr     = 1'b0;
  logic        reg_rd     = 1'b0;
  logic [11:0] reg_addr   = 12'h000;
  logic [7:0]  reg_wdata  = 8'h00;
  logic [7:0]  reg_rdata;
  logic [15:0] lane_active = 16'h00ff;
  logic [9:0]  ev         = 10'h000;
  logic        enc        = 1'b0;
  logic        sel        = 1'b1;
  logic        other      = 1'b0;
  logic        cal_status_pin;
  int          error_cnt  = 0;
  int          checked    = 0;

  // event stimulus, one bit per source
  logic [15:0] lane_fifo_fault;
  assign lane_fifo_fault = ev[5] ? 16'h8001 : 16'h0000;

  always #5 clock = ~clock;

  caa_alarm_aggregator uut (
    .clock              (clock),
    .rstn               (rstn),
    .soft_reset         (soft_reset),
    .reg_wr             (reg_wr),
    .reg_rd             (reg_rd),
    .reg_addr           (reg_addr),
    .reg_wdata          (reg_wdata),
    .reg_rdata          (reg_rdata),
    .lane_fifo_fault    (lane_fifo_fault),
    .lane_active        (lane_active),
    .pll_locked         (~ev[4]),
    .serial_link_enable (~ev[7]),
    .link_in_data_state (~ev[3]),
    .encoding_64b66b    (enc),
    .link_start         (ev[8]),
    .link_realign       (ev[9]),
    .sysref_realign     (ev[2]),
    .nco_sync           (ev[1]),
    .nco_phase_mismatch (ev[6]),
    .divider_mismatch   (ev[0]),
    .cal_status_sel     (sel),
    .cal_status_other   (other),
    .cal_status_pin     (cal_status_pin)
  );

  task automatic check(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, e);
  endtask : rd

  task automatic pin(input logic e);
    @(posedge clock);
    #1;
    check({7'h00, cal_status_pin}, {7'h00, e});
  endtask : pin

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  initial begin
    logic [7:0] e;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    rd(ADDR_ALARM_FLAGS, 8'h3f);
    rd(ADDR_ALARM_MASK, 8'h3f);
    rd(ADDR_LANE_FAULT_HI, 8'hff);
    rd(ADDR_ALARM_SUMMARY, 8'h00);
    pin(1'b0);
    // clear everything once the link is up
    wr(ADDR_ALARM_FLAGS, 8'h3f);
    rd(ADDR_ALARM_FLAGS, 8'h00);
    rd(ADDR_LANE_FAULT_LO, 8'h00);
    rd(ADDR_LANE_FAULT_HI, 8'h00);
    wr(ADDR_ALARM_MASK, 8'hff);
    rd(ADDR_ALARM_MASK, 8'h3f);
    wr(ADDR_ALARM_SUMMARY, 8'hff);
    rd(ADDR_ALARM_SUMMARY, 8'h00);
    rd(12'h2c3, 8'h00);
    wr(ADDR_ALARM_MASK, 8'h00);
    rd(ADDR_ALARM_SUMMARY, 8'h00);
    // every event source in turn
    for (int i = 0; i < 10; i++) begin
      e = 8'h01 << EBIT[i];
      @(posedge clock);
      enc <= (i >= 8);
      @(posedge clock);
      ev[i] <= 1'b1;
      @(posedge clock);
      ev[i] <= 1'b0;
      rd(ADDR_ALARM_FLAGS, e);
      rd(ADDR_ALARM_SUMMARY, 8'h01);
      pin(1'b1);
      wr(ADDR_ALARM_FLAGS, 8'h00);
      rd(ADDR_ALARM_FLAGS, e);
      wr(ADDR_ALARM_MASK, e);
      rd(ADDR_ALARM_SUMMARY, 8'h00);
      pin(1'b0);
      wr(ADDR_ALARM_MASK, 8'h00);
      if (i == 5) begin
        rd(ADDR_LANE_FAULT_LO, 8'h01);
        rd(ADDR_LANE_FAULT_HI, 8'h00);
      end
      wr(ADDR_ALARM_FLAGS, e);
      rd(ADDR_ALARM_FLAGS, 8'h00);
      if (i == 5) begin
        rd(ADDR_LANE_FAULT_LO, 8'h00);
      end
      @(posedge clock);
      enc <= 1'b0;
    end
    // set wins over a clear in the same cycle
    @(posedge clock);
    ev[0]     <= 1'b1;
    reg_wr    <= 1'b1;
    reg_addr  <= ADDR_ALARM_FLAGS;
    reg_wdata <= 8'h01;
    @(posedge clock);
    ev[0]  <= 1'b0;
    reg_wr <= 1'b0;
    rd(ADDR_ALARM_FLAGS, 8'h01);
    @(posedge clock);
    ev[0] <= 1'b0;
    wr(ADDR_ALARM_FLAGS, 8'h01);
    rd(ADDR_ALARM_FLAGS, 8'h00);
    // pin taken from the other source
    @(posedge clock);
    sel   <= 1'b0;
    other <= 1'b1;
    @(posedge clock);
    pin(1'b1);
    @(posedge clock);
    other <= 1'b0;
    pin(1'b0);
    // soft reset presets flags, mask and lanes
    @(posedge clock);
    soft_reset <= 1'b1;
    @(posedge clock);
    soft_reset <= 1'b0;
    rd(ADDR_ALARM_FLAGS, 8'h3f);
    rd(ADDR_ALARM_MASK, 8'h3f);
    rd(ADDR_LANE_FAULT_LO, 8'hff);
    conclude();
  end

endmodule : tb_converter_alarm_aggregator
